// file: gex_exit_logic.v
// What this block does
// - exit control set: flag ignored, interrupts exit
// - interrupt shadow blocking external: software selectable
// - interrupt shadow blocking NMI: software selectable
// - task switch attempt ends in exit unless a check faults
// - four ordered checks precede task switch exit
// - 64-bit mode software task gate faults
// - legacy task gate: gate privilege only
// - direct descriptor: faults 64-bit, else privilege checked
// - hardware events via gate: fault or unchecked
// - nested return: faults 64-bit, else unchecked
// - selector, descriptor read, descriptor fields checked
// - page fault versus task switch exit selectable
// - exception exit logs exception, and event only for hardware event or gated INT n/INT3/INTO switch
// - hardware event or gated INT n/INT3/INTO switch exit logs event, no interruption
// - timer counts down from entry value, expires
// - tick on each chosen counter bit change
// - counts up to C2, shutdown, startup wait
// - expiry wakes and exits, except startup wait
// - default management mode: exit after resume
// - dual monitor: timer halts in management mode
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`include "gex_consts.vh"

module gex_exit_logic #(
	parameter TW = 32,
	parameter [4:0] TSC_BIT = 5'h05
) (
	input wire mclk,
	input wire sys_rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire guest_mode,
	input wire vm_entry,
	input wire boundary,
	input wire [31:0] timestamp_counter,
	input wire [2:0] power_state,
	input wire shutdown,
	input wire wait_startup,
	input wire management_mode,
	input wire management_interrupt,
	input wire resume_from_management,
	input wire ext_int_req,
	input wire nmi_req,
	input wire interrupt_enable_flag,
	input wire shadow_active,
	input wire ts_req,
	input wire [2:0] ts_source,
	input wire ts_via_gate,
	input wire [10:0] ts_event,
	input wire long_mode,
	input wire nested_task_flag,
	input wire gate_present,
	input wire gate_priv_ok,
	input wire tss_priv_ok,
	input wire sel_ok,
	input wire desc_read_pf,
	input wire desc_ok,
	input wire tss_access_pf,
	input wire exc_takes_exit,
	input wire [10:0] exc_info,
	output reg exit_req,
	output reg [3:0] exit_reason,
	output reg guest_int_deliver,
	output reg fault_gp,
	output reg fault_pf,
	output reg ts_busy,
	output reg wake_c0
);

////////////////////////////////////////////////////////////////////////////////
// bus slave

reg [6:0] ctrl;
reg [TW-1:0] tload;
reg [3:0] last_reason;
reg [`GEX_INFO_W-1:0] vect_info;
reg [`GEX_INFO_W-1:0] intr_info;
reg wr_pend;
reg [7:0] wr_addr;
wire [TW-1:0] tcount;
wire texpired;
wire addr_phase;
reg [31:0] rd_mux;

assign addr_phase = hsel && hready && htrans[1];

always @* begin
	case (haddr[7:0])
	`GEX_REG_CTRL: rd_mux = {25'h0000000, ctrl};
	`GEX_REG_TLOAD: rd_mux = tload;
	`GEX_REG_TVAL: rd_mux = tcount;
	`GEX_REG_CAP: rd_mux = {27'h0000000, TSC_BIT};
	`GEX_REG_EXIT: rd_mux = {28'h0000000, last_reason};
	`GEX_REG_VECT: rd_mux = {20'h00000, vect_info};
	`GEX_REG_INTR: rd_mux = {20'h00000, intr_info};
	default: rd_mux = 32'h00000000;
	endcase
end

always @(posedge mclk or posedge sys_rst) begin
	if (sys_rst) begin
		hrdata <= 32'h00000000;
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		wr_pend <= 1'b0;
		wr_addr <= 8'h00;
		ctrl <= `GEX_CTRL_RST;
		tload <= {TW{1'b0}};
	end else begin
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		wr_pend <= addr_phase && hwrite;
		if (addr_phase) begin
			wr_addr <= haddr[7:0];
			if (!hwrite)
				hrdata <= rd_mux;
		end
		if (wr_pend) begin
			case (wr_addr)
			`GEX_REG_CTRL: ctrl <= hwdata[`GEX_CTRL_W-1:0];
			`GEX_REG_TLOAD: tload <= hwdata[TW-1:0];
			default: ;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt exiting

wire ext_blocked;
wire nmi_blocked;
wire ext_exit;
wire nmi_exit;

assign ext_blocked = shadow_active && ctrl[`GEX_CTRL_SHD_EXT];
assign nmi_blocked = shadow_active && ctrl[`GEX_CTRL_SHD_NMI];
// interrupt enable flag deliberately not consulted here
assign ext_exit = ctrl[`GEX_CTRL_EXT_EXIT] && ext_int_req && !ext_blocked;
assign nmi_exit = ctrl[`GEX_CTRL_NMI_EXIT] && nmi_req && !nmi_blocked;

////////////////////////////////////////////////////////////////////////////////
// task switch checks

localparam [2:0] TS_IDLE = 3'h0;
localparam [2:0] TS_GATE = 3'h1;
localparam [2:0] TS_SEL = 3'h2;
localparam [2:0] TS_READ = 3'h3;
localparam [2:0] TS_DESC = 3'h4;
localparam [2:0] TS_TSS = 3'h5;

reg [2:0] ts_state;
reg [2:0] next_ts_state;
reg [2:0] src;
reg idt_gate;
reg [10:0] ev;
reg ts_exit_pend;
reg exc_exit_pend;
reg next_gp;
reg next_pf;
reg next_ts_exit;
wire sw_gate;
wire gate_path;
wire is_bp_of;

assign is_bp_of = src == `GEX_SRC_INT3 || src == `GEX_SRC_INTO;
assign sw_gate = src == `GEX_SRC_CALL || src == `GEX_SRC_JMP || src == `GEX_SRC_INTN || is_bp_of;
assign gate_path = (sw_gate && ts_via_gate) || src == `GEX_SRC_HWEVT;

always @* begin
	next_ts_state = ts_state;
	next_gp = 1'b0;
	next_pf = 1'b0;
	next_ts_exit = 1'b0;
	case (ts_state)
	TS_IDLE: begin
		if (ts_req && guest_mode)
			next_ts_state = TS_GATE;
	end
	TS_GATE: begin
		next_ts_state = TS_SEL;
		if (src == `GEX_SRC_INTERRUPT_RETURN) begin
			if (long_mode && nested_task_flag)
				next_gp = 1'b1;
		end else if (gate_path) begin
			if (long_mode)
				next_gp = 1'b1;
			else if (!gate_present)
				next_gp = 1'b1;
			else if ((sw_gate || is_bp_of) && !gate_priv_ok)
				next_gp = 1'b1;
		end else begin
			if (long_mode)
				next_gp = 1'b1;
			else if (!tss_priv_ok)
				next_gp = 1'b1;
		end
		if (next_gp)
			next_ts_state = TS_IDLE;
	end
	TS_SEL: begin
		next_ts_state = TS_READ;
		if (!sel_ok) begin
			next_gp = 1'b1;
			next_ts_state = TS_IDLE;
		end
	end
	TS_READ: begin
		next_ts_state = TS_DESC;
		if (desc_read_pf) begin
			next_pf = 1'b1;
			next_ts_state = TS_IDLE;
		end
	end
	TS_DESC: begin
		next_ts_state = TS_TSS;
		if (!desc_ok) begin
			next_gp = 1'b1;
			next_ts_state = TS_IDLE;
		end
	end
	TS_TSS: begin
		next_ts_state = TS_IDLE;
		if (tss_access_pf && ctrl[`GEX_CTRL_PF_FIRST])
			next_pf = 1'b1;
		else
			next_ts_exit = 1'b1;
	end
	default: next_ts_state = TS_IDLE;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// preemption timer

reg tmr_armed;
reg tmr_pend;
wire cstate_ok;
wire mgmt_hold;
wire tmr_run;

assign cstate_ok = power_state <= `GEX_CSTATE_MAX;
// dual monitor: management mode is outside the guest, so the timer halts
assign mgmt_hold = management_mode && ctrl[`GEX_CTRL_DUAL_MON];
assign tmr_run = tmr_armed && (guest_mode || management_mode) && cstate_ok && !mgmt_hold;

gex_timer #(
	.TW(TW)
) u_timer (
	.mclk(mclk),
	.sys_rst(sys_rst),
	.timestamp_counter(timestamp_counter),
	.tsc_bit_sel(TSC_BIT),
	.load(vm_entry),
	.load_value(tload),
	.run(tmr_run),
	.count(tcount),
	.expired(texpired)
);

////////////////////////////////////////////////////////////////////////////////
// exit arbitration: task switch, exception, NMI, external, timer

reg next_exit;
reg [3:0] next_reason;
wire can_exit;

// no exits from management mode; a timer expiry waits for resume
assign can_exit = guest_mode && !management_mode && boundary;

always @* begin
	next_exit = 1'b0;
	next_reason = `GEX_RSN_NONE;
	if (guest_mode && !management_mode) begin
		if (ts_exit_pend) begin
			next_exit = 1'b1;
			next_reason = `GEX_RSN_TS;
		end else if (exc_exit_pend) begin
			next_exit = 1'b1;
			next_reason = `GEX_RSN_EXC;
		end else if (can_exit && nmi_exit) begin
			next_exit = 1'b1;
			next_reason = `GEX_RSN_NMI;
		end else if (can_exit && ext_exit) begin
			next_exit = 1'b1;
			next_reason = `GEX_RSN_EXT;
		end else if (can_exit && tmr_pend && !wait_startup) begin
			next_exit = 1'b1;
			next_reason = `GEX_RSN_TMR;
		end
	end
end

always @(posedge mclk or posedge sys_rst) begin
	if (sys_rst) begin
		ts_state <= TS_IDLE;
		src <= `GEX_SRC_CALL;
		idt_gate <= 1'b0;
		ev <= 11'h000;
		ts_exit_pend <= 1'b0;
		exc_exit_pend <= 1'b0;
		vect_info <= {`GEX_INFO_W{1'b0}};
		intr_info <= {`GEX_INFO_W{1'b0}};
		last_reason <= `GEX_RSN_NONE;
		tmr_armed <= 1'b0;
		tmr_pend <= 1'b0;
		exit_req <= 1'b0;
		exit_reason <= `GEX_RSN_NONE;
		guest_int_deliver <= 1'b0;
		fault_gp <= 1'b0;
		fault_pf <= 1'b0;
		ts_busy <= 1'b0;
		wake_c0 <= 1'b0;
	end else begin
		ts_state <= next_ts_state;
		ts_busy <= next_ts_state != TS_IDLE;
		fault_gp <= next_gp;
		fault_pf <= next_pf;
		if (ts_state == TS_IDLE && ts_req) begin
			src <= ts_source;
			idt_gate <= ts_source == `GEX_SRC_HWEVT || (ts_via_gate && ts_source != `GEX_SRC_CALL
				&& ts_source != `GEX_SRC_JMP && ts_source != `GEX_SRC_INTERRUPT_RETURN);
			ev <= ts_event;
		end
		if (next_exit && next_reason == `GEX_RSN_TS)
			ts_exit_pend <= 1'b0;
		if (next_exit && next_reason == `GEX_RSN_EXC)
			exc_exit_pend <= 1'b0;
		if (next_ts_exit) begin
			ts_exit_pend <= 1'b1;
			vect_info <= idt_gate ? {1'b1, ev} : {`GEX_INFO_W{1'b0}};
			intr_info <= {`GEX_INFO_W{1'b0}};
		end else if ((next_gp || next_pf) && exc_takes_exit) begin
			exc_exit_pend <= 1'b1;
			// the event is stored only for hardware events and for INT n, INT3 or INTO switches through a gate
			vect_info <= idt_gate ? {1'b1, ev} : {`GEX_INFO_W{1'b0}};
			intr_info <= {1'b1, exc_info};
		end
		if (vm_entry) begin
			tmr_armed <= ctrl[`GEX_CTRL_TMR_ACT];
			tmr_pend <= 1'b0;
		end else if (texpired && tmr_armed && !tmr_pend) begin
			tmr_pend <= !wait_startup;
			tmr_armed <= 1'b0;
		end else if (next_exit && next_reason == `GEX_RSN_TMR) begin
			tmr_pend <= 1'b0;
		end
		wake_c0 <= tmr_pend && !wait_startup && !management_mode
			&& power_state != `GEX_CSTATE_C0;
		exit_req <= next_exit;
		exit_reason <= next_reason;
		if (next_exit)
			last_reason <= next_reason;
		guest_int_deliver <= guest_mode && !ctrl[`GEX_CTRL_EXT_EXIT] && ext_int_req
			&& interrupt_enable_flag && !shadow_active;
	end
end

endmodule

// file: gex_consts.vh
`ifndef GEX_CONSTS_VH
`define GEX_CONSTS_VH

// register byte offsets
`define GEX_REG_CTRL 8'h00
`define GEX_REG_TLOAD 8'h04
`define GEX_REG_TVAL 8'h08
`define GEX_REG_CAP 8'h0C
`define GEX_REG_EXIT 8'h10
`define GEX_REG_VECT 8'h14
`define GEX_REG_INTR 8'h18

// control register fields
`define GEX_CTRL_EXT_EXIT 0
`define GEX_CTRL_NMI_EXIT 1
`define GEX_CTRL_TMR_ACT 2
`define GEX_CTRL_SHD_EXT 3
`define GEX_CTRL_SHD_NMI 4
`define GEX_CTRL_PF_FIRST 5
`define GEX_CTRL_DUAL_MON 6
`define GEX_CTRL_W 7
`define GEX_CTRL_RST 7'h00

// exit reasons
`define GEX_RSN_NONE 4'h0
`define GEX_RSN_EXC 4'h1
`define GEX_RSN_EXT 4'h2
`define GEX_RSN_NMI 4'h3
`define GEX_RSN_TS 4'h4
`define GEX_RSN_TMR 4'h5

// task switch sources
`define GEX_SRC_CALL 3'h0
`define GEX_SRC_JMP 3'h1
`define GEX_SRC_INTN 3'h2
`define GEX_SRC_INT3 3'h3
`define GEX_SRC_INTO 3'h4
`define GEX_SRC_HWEVT 3'h5
`define GEX_SRC_INTERRUPT_RETURN 3'h6

// power states: the active one, and the deepest that keeps the timer running
`define GEX_CSTATE_C0 3'h0
`define GEX_CSTATE_MAX 3'h2

// event info layout: valid in bit 11, type 10:8, vector 7:0
`define GEX_INFO_VALID 11
`define GEX_INFO_W 12

`endif

// file: gex_timer.v
`include "gex_consts.vh"

module gex_timer #(
	parameter TW = 32
) (
	input wire mclk,
	input wire sys_rst,
	input wire [31:0] timestamp_counter,
	input wire [4:0] tsc_bit_sel,
	input wire load,
	input wire [TW-1:0] load_value,
	input wire run,
	output reg [TW-1:0] count,
	output reg expired
);

reg tsc_bit_prev;
wire tsc_bit;
wire tick;

assign tsc_bit = timestamp_counter[tsc_bit_sel];
// a change of the chosen bit is one timer tick
assign tick = tsc_bit ^ tsc_bit_prev;

always @(posedge mclk or posedge sys_rst) begin
	if (sys_rst) begin
		tsc_bit_prev <= 1'b0;
		count <= {TW{1'b0}};
		expired <= 1'b0;
	end else begin
		tsc_bit_prev <= tsc_bit;
		if (load) begin
			count <= load_value;
			expired <= 1'b0;
		end else if (run && tick && count != {TW{1'b0}}) begin
			count <= count - {{(TW-1){1'b0}}, 1'b1};
			if (count == {{(TW-1){1'b0}}, 1'b1})
				expired <= 1'b1;
		end
	end
end

endmodule

// file: gex_exit_props.sv
`include "gex_consts.vh"

module gex_exit_props (
	input wire mclk,
	input wire sys_rst,
	input wire hreadyout,
	input wire hresp,
	input wire guest_mode,
	input wire boundary,
	input wire ext_int_req,
	input wire wait_startup,
	input wire ts_req,
	input wire [2:0] ts_source,
	input wire long_mode,
	input wire ts_via_gate,
	input wire ts_busy,
	input wire exit_req,
	input wire [3:0] exit_reason,
	input wire fault_gp
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////
	sequence ts_take;
		ts_req && guest_mode && !ts_busy;
	endsequence
	sequence gate_fail;
		##[1:3] fault_gp;
	endsequence
	AST_HREADY: assert property (hreadyout) else $error("wait state inserted");
	AST_HRESP: assert property (!hresp) else $error("error response");
	AST_TS_BUSY: assert property (ts_take |=> ts_busy) else $error("switch not taken");
	AST_TS_GP: assert property (ts_take and (long_mode && ts_via_gate
		&& ts_source != `GEX_SRC_INTERRUPT_RETURN) |-> gate_fail) else $error("gate in long mode did not fault");
	AST_TS_EXIT: assert property (exit_req && exit_reason == `GEX_RSN_TS |-> $past(ts_busy, 2))
		else $error("switch exit before checks");
	AST_GP_PULSE: assert property ($rose(fault_gp) |=> !fault_gp) else $error("fault not a pulse");
	AST_REASON: assert property (exit_req |-> exit_reason inside {[1:5]})
		else $error("bad exit reason");
	AST_EXT: assert property (exit_req && exit_reason == `GEX_RSN_EXT |->
		$past(ext_int_req && boundary && guest_mode)) else $error("external exit without cause");
	AST_TMR: assert property (exit_req && exit_reason == `GEX_RSN_TMR |->
		$past(boundary && !wait_startup)) else $error("timer exit in startup wait");
endmodule

bind gex_exit_logic gex_exit_props gex_exit_props_i (.*);

// file: tb.sv
`include "gex_consts.vh"

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 0, sys_rst = 1, hsel = 0, hwrite = 0, guest_mode = 0, vm_entry = 0, boundary = 0;
	logic shutdown = 0, wait_startup = 0, management_mode = 0, ext_int_req = 0, nmi_req = 0;
	logic interrupt_enable_flag = 0, shadow_active = 0, ts_req = 0, ts_via_gate = 0, long_mode = 0;
	logic nested_task_flag = 0, gate_present = 0, gate_priv_ok = 0, tss_priv_ok = 0, sel_ok = 0;
	logic desc_read_pf = 0, desc_ok = 0, tss_access_pf = 0, management_interrupt = 0;
	logic resume_from_management = 0, exc_takes_exit = 0, g, p, gd;
	logic [31:0] haddr = 0, hwdata = 0, timestamp_counter = 0, r;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2, ts_source = 0, power_state = 0;
	logic [10:0] ts_event = 0, exc_info = 0;
	logic [3:0] rs;
	wire hready, hreadyout, hresp, exit_req, guest_int_deliver, fault_gp, fault_pf, ts_busy, wake_c0;
	wire [31:0] hrdata;
	wire [3:0] exit_reason;
	int fail_count = 0, comparisons = 0;
	assign hready = hreadyout;
	gex_exit_logic #(.TSC_BIT(5'h05)) gex_exit_logic_i (.*);
	initial begin
		forever #2 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////
	task tally_and_finish;
		$display("checks %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task watch;
		rs = 0;
		g = 0;
		p = 0;
		gd = 0;
		repeat (12) begin
			#1;
			if (exit_req === 1'b1) rs = exit_reason;
			if (fault_gp === 1'b1) g = 1;
			if (fault_pf === 1'b1) p = 1;
			if (guest_int_deliver === 1'b1) gd = 1;
			@(posedge mclk);
		end
	endtask
	task pulse(input int k);
		@(posedge mclk);
		if (k == 0) boundary <= 1;
		else vm_entry <= 1;
		@(posedge mclk);
		boundary <= 0;
		vm_entry <= 0;
	endtask
	task ev(input logic [6:0] ctrl, input logic [4:0] s, input logic [3:0] e);
		ahb(1, `GEX_REG_CTRL, {25'h0, ctrl});
		@(posedge mclk);
		{ext_int_req, nmi_req, interrupt_enable_flag, shadow_active, management_mode} <= s;
		pulse(0);
		watch;
		{ext_int_req, nmi_req, interrupt_enable_flag, shadow_active, management_mode} <= 5'h00;
		chk(32'(rs), 32'(e));
	endtask
	task ts(input logic lm, input logic [2:0] src, input logic [7:0] ck, input logic [5:0] e);
		@(posedge mclk);
		long_mode <= lm;
		ts_source <= src;
		{ts_via_gate, gate_present, gate_priv_ok, tss_priv_ok, sel_ok, desc_read_pf, desc_ok,
			tss_access_pf} <= ck;
		ts_req <= 1;
		@(posedge mclk);
		ts_req <= 0;
		watch;
		chk(32'({rs, g, p}), 32'(e));
	endtask
	task tick(input logic [31:0] e);
		@(posedge mclk);
		timestamp_counter <= timestamp_counter + 32'h20;
		repeat (3) @(posedge mclk);
		ahb(0, `GEX_REG_TVAL, 32'h0);
		chk(r, e);
	endtask
	initial begin
		#40000;
		fail_count++;
		tally_and_finish;
	end
	initial begin
		repeat (3) @(posedge mclk);
		sys_rst <= 0;
		guest_mode <= 1;
		ahb(0, `GEX_REG_CTRL, 32'h0);
		chk(r, 32'h0);
		ahb(1, `GEX_REG_CAP, 32'hFFFFFFFF);
		ahb(0, `GEX_REG_CAP, 32'h0);
		chk(r, 32'h5);
		ahb(1, 32'h40, 32'hFFFFFFFF);
		ahb(0, 32'h40, 32'h0);
		chk(r, 32'h0);
		ahb(1, `GEX_REG_CTRL, 32'hFFFFFFFF);
		ahb(0, `GEX_REG_CTRL, 32'h0);
		chk(r, 32'h7F);
		$display("test registers done");
		ev(7'h01, 5'b10000, `GEX_RSN_EXT);
		ahb(0, `GEX_REG_EXIT, 32'h0);
		chk(r, 32'h2);
		ev(7'h02, 5'b01000, `GEX_RSN_NMI);
		ev(7'h09, 5'b10010, `GEX_RSN_NONE);
		ev(7'h01, 5'b10010, `GEX_RSN_EXT);
		ev(7'h12, 5'b01010, `GEX_RSN_NONE);
		ev(7'h03, 5'b11000, `GEX_RSN_NMI);
		ev(7'h01, 5'b10001, `GEX_RSN_NONE);
		ev(7'h00, 5'b10100, `GEX_RSN_NONE);
		chk(32'(gd), 32'h1);
		$display("test events done");
		ahb(1, `GEX_REG_CTRL, 32'h0);
		ts_event <= 11'h30E;
		ts(0, `GEX_SRC_HWEVT, 8'hFA, 6'h10);
		ahb(0, `GEX_REG_VECT, 32'h0);
		chk(r, 32'h00000B0E);
		ahb(0, `GEX_REG_INTR, 32'h0);
		chk(32'(r[11]), 32'h0);
		ts(1, `GEX_SRC_CALL, 8'hFA, 6'h02);
		ts(0, `GEX_SRC_INT3, 8'hDA, 6'h02);
		ts(0, `GEX_SRC_JMP, 8'hEA, 6'h10);
		ts(1, `GEX_SRC_JMP, 8'h7A, 6'h02);
		ts(0, `GEX_SRC_CALL, 8'h6A, 6'h02);
		ts(0, `GEX_SRC_CALL, 8'hF2, 6'h02);
		ts(0, `GEX_SRC_CALL, 8'hFE, 6'h01);
		ts(0, `GEX_SRC_CALL, 8'hDE, 6'h02);
		ts(0, `GEX_SRC_CALL, 8'hFB, 6'h10);
		nested_task_flag <= 1;
		ts(1, `GEX_SRC_INTERRUPT_RETURN, 8'h7A, 6'h02);
		ahb(1, `GEX_REG_CTRL, 32'h20);
		ts(0, `GEX_SRC_CALL, 8'hFB, 6'h01);
		exc_takes_exit <= 1;
		exc_info <= 11'h30D;
		ts(0, `GEX_SRC_HWEVT, 8'hBA, 6'h06);
		ahb(0, `GEX_REG_VECT, 32'h0);
		chk(r, 32'h00000B0E);
		ahb(0, `GEX_REG_INTR, 32'h0);
		chk(r, 32'h00000B0D);
		exc_takes_exit <= 0;
		$display("test task switch done");
		ahb(1, `GEX_REG_TLOAD, 32'h3);
		ahb(1, `GEX_REG_CTRL, 32'h4);
		pulse(1);
		ahb(0, `GEX_REG_TVAL, 32'h0);
		chk(r, 32'h3);
		tick(32'h2);
		power_state <= 3'h3;
		tick(32'h2);
		power_state <= `GEX_CSTATE_MAX;
		shutdown <= 1;
		tick(32'h1);
		shutdown <= 0;
		tick(32'h0);
		chk(32'(wake_c0), 32'h1);
		power_state <= 3'h0;
		pulse(0);
		watch;
		chk(32'(rs), 32'(`GEX_RSN_TMR));
		chk(32'(wake_c0), 32'h0);
		ahb(1, `GEX_REG_TLOAD, 32'h2);
		pulse(1);
		management_mode <= 1;
		tick(32'h1);
		ahb(1, `GEX_REG_CTRL, 32'h44);
		tick(32'h1);
		ahb(1, `GEX_REG_CTRL, 32'h4);
		tick(32'h0);
		pulse(0);
		watch;
		chk(32'(rs), 32'(`GEX_RSN_NONE));
		management_mode <= 0;
		pulse(0);
		watch;
		chk(32'(rs), 32'(`GEX_RSN_TMR));
		ahb(1, `GEX_REG_TLOAD, 32'h1);
		pulse(1);
		wait_startup <= 1;
		tick(32'h0);
		pulse(0);
		watch;
		chk(32'(rs), 32'(`GEX_RSN_NONE));
		$display("test timer done");
		tally_and_finish;
	end
endmodule
